//--- hdl/gtr_timing_framer.sv
// Purpose: Frames primary and supplemental timing reports into a byte stream
// Assumes: Receiver core supplies time, position and a second pulse
// Notes:   Registers on Avalon-MM; the host request arrives as a two-byte packet
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gtr_timing_framer
  import gtr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Receiver core
  input  wire logic        secPulse,
  input  wire gtr_time_s   timeIn,
  input  wire logic        todLoad,
  input  wire logic [23:0] todLoadValue,
  input  wire logic        surveyActive,
  input  wire logic        timeOnlyMode,
  input  wire logic        surveyDone,
  input  wire gtr_pos_s    surveyPos,
  input  wire gtr_pos_s    storedPos,
  input  wire gtr_pos_s    fixPos,
  // Host request bytes
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqByte,
  // Report byte stream
  output gtr_byte_s        txOut,
  input  wire logic        txReady
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRIM = 2'b01,
    ST_SUPP = 2'b11
  } gtr_tx_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic        waitBus;
    logic [31:0] rdata;
    gtr_tx_e     st;
    logic [4:0]  idx;
    logic        pendPrim;
    logic        pendSupp;
    logic        reqHold;
    logic        reqArmed;
    logic        holdSupp;
    logic        holdBoth;
    logic [15:0] primCount;
    logic [15:0] suppCount;
    gtr_byte_s   tx;
  } gtr_state_s;

  gtr_state_s s_q;
  gtr_state_s s_d;

  logic [7:0]  todSec;
  logic [7:0]  todMin;
  logic [7:0]  todHour;
  logic [15:0] weekAdj;
  logic [15:0] leapOut;
  logic [7:0]  flags;
  gtr_pos_s    posSel;
  gtr_pos_e    posSrc;
  logic [7:0]  primByte;
  logic [7:0]  suppByte;
  logic        txAdvance;

  // Time of day counter
  gtr_clock_of_day u_tod (
    .clock      (clock),
    .arst_n     (arst_n),
    .tick       (secPulse),
    .load       (todLoad),
    .loadSec    (todLoadValue[7:0]),
    .loadMin    (todLoadValue[15:8]),
    .loadHour   (todLoadValue[23:16]),
    .leapInsert (timeIn.leapInsert & timeIn.useUtc & timeIn.utcKnown),
    .seconds    (todSec),
    .minutes    (todMin),
    .hours      (todHour),
    .dayWrap    ()
  );

  // Field encoding
  always_comb begin
    weekAdj = {6'h00, timeIn.weekRaw};
    if (timeIn.weekRaw < WeekLimit) begin
      weekAdj = {6'h00, timeIn.weekRaw} + WeekAdd;
    end
    leapOut = timeIn.utcKnown ? timeIn.leapOffset : 16'h0000;
    flags                = 8'h00;
    flags[FlagUtc]       = timeIn.useUtc & timeIn.utcKnown;
    flags[FlagNoTime]    = ~timeIn.timeSet;
    flags[FlagNoLeap]    = ~timeIn.utcKnown;
  end

  // Position source
  always_comb begin
    if (surveyActive) begin
      posSrc = POS_SURVEY;
      posSel = surveyPos;
    end else if (surveyDone || timeOnlyMode) begin
      posSrc = POS_STORED;
      posSel = storedPos;
    end else begin
      posSrc = POS_FIX;
      posSel = fixPos;
    end
  end

  // Primary report byte, most significant byte first
  always_comb begin
    unique case (s_q.idx)
      5'd0:    primByte = PrimSubcode;
      5'd1:    primByte = timeIn.secWeek[31:24];
      5'd2:    primByte = timeIn.secWeek[23:16];
      5'd3:    primByte = timeIn.secWeek[15:8];
      5'd4:    primByte = timeIn.secWeek[7:0];
      5'd5:    primByte = weekAdj[15:8];
      5'd6:    primByte = weekAdj[7:0];
      5'd7:    primByte = leapOut[15:8];
      5'd8:    primByte = leapOut[7:0];
      5'd9:    primByte = flags;
      5'd10:   primByte = todSec;
      5'd11:   primByte = todMin;
      5'd12:   primByte = todHour;
      5'd13:   primByte = timeIn.day;
      5'd14:   primByte = timeIn.month;
      5'd15:   primByte = timeIn.year[15:8];
      5'd16:   primByte = timeIn.year[7:0];
      default: primByte = 8'h00;
    endcase
  end

  // Supplemental report byte: subcode, source, three positions
  always_comb begin
    unique case (s_q.idx)
      5'd0:    suppByte = SuppSubcode;
      5'd1:    suppByte = {6'h00, posSrc};
      5'd2:    suppByte = posSel.posA[31:24];
      5'd3:    suppByte = posSel.posA[23:16];
      5'd4:    suppByte = posSel.posA[15:8];
      5'd5:    suppByte = posSel.posA[7:0];
      5'd6:    suppByte = posSel.posB[31:24];
      5'd7:    suppByte = posSel.posB[23:16];
      5'd8:    suppByte = posSel.posB[15:8];
      5'd9:    suppByte = posSel.posB[7:0];
      5'd10:   suppByte = posSel.posC[31:24];
      5'd11:   suppByte = posSel.posC[23:16];
      5'd12:   suppByte = posSel.posC[15:8];
      5'd13:   suppByte = posSel.posC[7:0];
      default: suppByte = 8'h00;
    endcase
  end

  assign txAdvance = !s_q.tx.valid || txReady;

  // Next state
  always_comb begin
    s_d = s_q;
    // Bus slave: one wait cycle, then answer
    s_d.waitBus = 1'b1;
    if ((read || write) && s_q.waitBus) begin
      s_d.waitBus = 1'b0;
      unique case (address)
        OffCtrl:     s_d.rdata = s_q.ctrl;
        OffStatus:   s_d.rdata = {24'h0, flags[3:0], s_q.pendSupp, s_q.pendPrim,
                                  s_q.st};
        OffSecWeek:  s_d.rdata = timeIn.secWeek;
        OffWeekLeap: s_d.rdata = {weekAdj, leapOut};
        OffDate:     s_d.rdata = {timeIn.year, timeIn.month, timeIn.day};
        OffTime:     s_d.rdata = {8'h00, todHour, todMin, todSec};
        OffCount:    s_d.rdata = {s_q.suppCount, s_q.primCount};
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Write lands at the edge where waitrequest is seen low
    if (write && !s_q.waitBus && address == OffCtrl) begin
      s_d.ctrl = writedata & CtrlReset;
    end
    // Byte stream: primary first so supplemental follows it
    if (txAdvance) begin
      s_d.tx.valid = 1'b0;
      s_d.tx.first = 1'b0;
      s_d.tx.last  = 1'b0;
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.idx = 5'd0;
          if (s_q.pendPrim) begin
            s_d.st       = ST_PRIM;
            s_d.pendPrim = 1'b0;
          end else if (s_q.pendSupp) begin
            s_d.st       = ST_SUPP;
            s_d.pendSupp = 1'b0;
          end
        end
        ST_PRIM: begin
          s_d.tx.valid = 1'b1;
          s_d.tx.data  = primByte;
          s_d.tx.first = (s_q.idx == 5'd0);
          s_d.tx.last  = (s_q.idx == PrimLen - 5'd1);
          s_d.idx      = s_q.idx + 5'd1;
          if (s_q.idx == PrimLen - 5'd1) begin
            s_d.st        = ST_IDLE;
            s_d.primCount = s_q.primCount + 16'h0001;
          end
        end
        ST_SUPP: begin
          s_d.tx.valid = 1'b1;
          s_d.tx.data  = suppByte;
          s_d.tx.first = (s_q.idx == 5'd0);
          s_d.tx.last  = (s_q.idx == SuppLen - 5'd1);
          s_d.idx      = s_q.idx + 5'd1;
          if (s_q.idx == SuppLen - 5'd1) begin
            s_d.st        = ST_IDLE;
            s_d.suppCount = s_q.suppCount + 16'h0001;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    // Second pulse schedules the reports; sets follow the stream's clears
    if (secPulse) begin
      if (s_q.ctrl[BitPrimEn] || s_q.holdBoth) begin
        s_d.pendPrim = 1'b1;
      end
      if (s_q.ctrl[BitSuppEn] || s_q.holdSupp || s_q.holdBoth) begin
        s_d.pendSupp = 1'b1;
      end
      s_d.holdSupp = 1'b0;
      s_d.holdBoth = 1'b0;
    end
    // Host request parser, last so a new request wins over a clear
    if (reqValid) begin
      if (!s_q.reqArmed) begin
        s_d.reqArmed = (reqByte == SuppSubcode);
      end else begin
        s_d.reqArmed = 1'b0;
        unique case (reqByte)
          8'h00:   s_d.pendSupp = 1'b1;
          8'h01:   s_d.holdSupp = 1'b1;
          8'h02:   s_d.holdBoth = 1'b1;
          default: s_d.reqArmed = 1'b0;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q         <= '0;
      s_q.ctrl    <= CtrlReset;
      s_q.waitBus <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata    = s_q.rdata;
  assign waitrequest = s_q.waitBus;
  assign txOut       = s_q.tx;

  a_prim_sched: assert property (@(posedge clock) disable iff (!arst_n)
    secPulse && s_q.ctrl[BitPrimEn] |=> s_q.pendPrim || s_q.st == ST_PRIM)
    else $error("primary report not scheduled on pulse");
  a_prim_start: assert property (@(posedge clock) disable iff (!arst_n)
    secPulse && s_q.ctrl[BitPrimEn] && s_q.st == ST_IDLE && !s_q.pendSupp && txReady
    |-> ##[1:40] (txOut.valid && txOut.first && txOut.data == PrimSubcode))
    else $error("primary report late");
  a_week_adjust: assert property (@(posedge clock) disable iff (!arst_n)
    weekAdj == {((timeIn.weekRaw < WeekLimit) ? 6'h01 : 6'h00), timeIn.weekRaw})
    else $error("week number not adjusted");
  a_leap_zero: assert property (@(posedge clock) disable iff (!arst_n)
    !timeIn.utcKnown |-> leapOut == 16'h0000 && flags[FlagNoLeap])
    else $error("leap offset shown before known");
  a_flag_time: assert property (@(posedge clock) disable iff (!arst_n)
    flags[FlagNoTime] == !timeIn.timeSet && (flags[FlagUtc] -> timeIn.utcKnown))
    else $error("timing flags wrong");
  a_req_now: assert property (@(posedge clock) disable iff (!arst_n)
    reqValid && s_q.reqArmed && reqByte == 8'h00 |=> s_q.pendSupp || s_q.st == ST_SUPP)
    else $error("immediate request not taken");
  a_req_hold: assert property (@(posedge clock) disable iff (!arst_n)
    reqValid && s_q.reqArmed && reqByte == 8'h01 && !secPulse |=> s_q.holdSupp)
    else $error("held request lost");
  a_supp_after: assert property (@(posedge clock) disable iff (!arst_n)
    s_q.st == ST_IDLE && s_q.pendPrim && s_q.pendSupp && txAdvance |=> s_q.st == ST_PRIM)
    else $error("supplemental broke order");
  a_pos_survey: assert property (@(posedge clock) disable iff (!arst_n)
    surveyActive |-> posSel == surveyPos)
    else $error("wrong position source");

  // Bus handshake, stream hold, report layout, requests, position source and flags
  a_bus_wait: assert property (@(posedge clock) disable iff (!arst_n)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered");
  a_tx_hold: assert property (@(posedge clock) disable iff (!arst_n)
    txOut.valid && !txReady |=> $stable(txOut))
    else $error("report byte changed while stalled");
  a_prim_layout: assert property (@(posedge clock) disable iff (!arst_n)
    s_q.st == ST_PRIM && s_q.idx == 5'd0 && txAdvance
    |=> txOut.valid && txOut.first && txOut.data == PrimSubcode)
    else $error("primary report does not open with its subcode");
  a_supp_last: assert property (@(posedge clock) disable iff (!arst_n)
    s_q.st == ST_SUPP && s_q.idx == SuppLen - 5'd1 && txAdvance
    |=> txOut.valid && txOut.last)
    else $error("supplemental report length wrong");
  a_req_both: assert property (@(posedge clock) disable iff (!arst_n)
    reqValid && s_q.reqArmed && reqByte == 8'h02 |=> s_q.holdBoth)
    else $error("request for both reports lost");
  a_pos_stored: assert property (@(posedge clock) disable iff (!arst_n)
    !surveyActive && (surveyDone || timeOnlyMode) |-> posSel == storedPos)
    else $error("stored position not chosen");
  a_flag_utc: assert property (@(posedge clock) disable iff (!arst_n)
    timeIn.useUtc && timeIn.utcKnown |-> flags[FlagUtc])
    else $error("UTC scale flag not set");

endmodule
`default_nettype wire

//--- shared/gtr_pkg.sv
// Purpose: Shared constants and carriers for the timing report framer
// Assumes: 100 MHz system clock, byte-wide report stream
// Notes:   Register map, report layout and timing counts live here
package gtr_pkg;

  // Clock and timing
  localparam int unsigned ClkMhz      = 100;
  localparam int unsigned PrimLatMs   = 30;
  localparam int unsigned SuppLatMs   = 300;
  localparam int unsigned PrimLatCyc  = PrimLatMs * ClkMhz * 1000;
  localparam int unsigned SuppLatCyc  = SuppLatMs * ClkMhz * 1000;

  // Avalon register offsets (byte addresses)
  localparam logic [5:0] OffCtrl      = 6'h00;
  localparam logic [5:0] OffStatus    = 6'h04;
  localparam logic [5:0] OffSecWeek   = 6'h08;
  localparam logic [5:0] OffWeekLeap  = 6'h0c;
  localparam logic [5:0] OffDate      = 6'h10;
  localparam logic [5:0] OffTime      = 6'h14;
  localparam logic [5:0] OffCount     = 6'h18;

  // Control field positions and reset value
  localparam int unsigned BitPrimEn   = 6;
  localparam int unsigned BitSuppEn   = 7;
  localparam logic [31:0] CtrlReset   = 32'h0000_00c0;

  // Report layout
  localparam logic [7:0]  PrimSubcode = 8'hab;
  localparam logic [7:0]  SuppSubcode = 8'hac;
  localparam logic [4:0]  PrimLen     = 5'h11;
  localparam logic [4:0]  SuppLen     = 5'h0e;
  localparam logic [9:0]  WeekLimit   = 10'h3ff;
  localparam logic [15:0] WeekAdd     = 16'h0400;
  localparam int unsigned FlagUtc     = 0;
  localparam int unsigned FlagNoTime  = 2;
  localparam int unsigned FlagNoLeap  = 3;

  // Position source selector
  typedef enum logic [1:0] {
    POS_FIX    = 2'h0,
    POS_SURVEY = 2'h1,
    POS_STORED = 2'h2
  } gtr_pos_e;

  // Time carrier from the receiver core
  typedef struct packed {
    logic [31:0] secWeek;
    logic [9:0]  weekRaw;
    logic [15:0] leapOffset;
    logic        utcKnown;
    logic        timeSet;
    logic        useUtc;
    logic        leapInsert;
    logic [7:0]  day;
    logic [7:0]  month;
    logic [15:0] year;
  } gtr_time_s;

  // Position carrier (compact, three axes)
  typedef struct packed {
    logic [31:0] posA;
    logic [31:0] posB;
    logic [31:0] posC;
  } gtr_pos_s;

  // Outgoing byte stream
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } gtr_byte_s;

endpackage

//--- hdl/gtr_clock_of_day.sv
// Purpose: Hours, minutes and seconds counter advanced on each second pulse
// Assumes: tick is a one-cycle pulse; load sets the time directly
// Notes:   Leap insertion stretches 23:59:59 into 23:59:60
`timescale 1ns/100ps
`default_nettype none
module gtr_clock_of_day
  import gtr_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Control
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] loadSec,
  input  wire logic [7:0] loadMin,
  input  wire logic [7:0] loadHour,
  input  wire logic       leapInsert,
  // Time of day
  output logic      [7:0] seconds,
  output logic      [7:0] minutes,
  output logic      [7:0] hours,
  output logic            dayWrap
);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic       wrap;
  } gtr_tod_s;

  gtr_tod_s state_q;
  gtr_tod_s state_d;

  // Next time of day
  always_comb begin
    state_d      = state_q;
    state_d.wrap = 1'b0;
    if (load) begin
      state_d.sec  = loadSec;
      state_d.min  = loadMin;
      state_d.hour = loadHour;
    end else if (tick) begin
      if (state_q.sec == 8'h3c) begin
        state_d.sec  = 8'h00;
        state_d.min  = 8'h00;
        state_d.hour = 8'h00;
        state_d.wrap = 1'b1;
      end else if (state_q.sec == 8'h3b && state_q.min == 8'h3b
                   && state_q.hour == 8'h17 && leapInsert) begin
        state_d.sec = 8'h3c;
      end else if (state_q.sec != 8'h3b) begin
        state_d.sec = state_q.sec + 8'h01;
      end else begin
        state_d.sec = 8'h00;
        if (state_q.min != 8'h3b) begin
          state_d.min = state_q.min + 8'h01;
        end else begin
          state_d.min = 8'h00;
          if (state_q.hour != 8'h17) begin
            state_d.hour = state_q.hour + 8'h01;
          end else begin
            state_d.hour = 8'h00;
            state_d.wrap = 1'b1;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign seconds = state_q.sec;
  assign minutes = state_q.min;
  assign hours   = state_q.hour;
  assign dayWrap = state_q.wrap;

  a_tod_range: assert property (@(posedge clock) disable iff (!arst_n)
    state_q.sec <= 8'h3c && state_q.min <= 8'h3b && state_q.hour <= 8'h17)
    else $error("time of day out of range");

endmodule
`default_nettype wire

//--- tb/gtr_host_model.sv
// Purpose: Host side of the report link: sinks report bytes, sends requests
// Assumes: A byte moves on an edge where valid and ready are both high
// Notes:   slow throttles ready so the framer must hold its bytes
`timescale 1ns/100ps
`default_nettype none
module gtr_host_model
  import gtr_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      arst_n,
  // Report stream
  input  wire gtr_byte_s txOut,
  output logic           txReady,
  input  wire logic      slow,
  // Request bytes
  output logic           reqValid,
  output logic     [7:0] reqByte
);
  logic [2:0] cnt;
  logic [7:0] rxQ[$];

  // Sink in arrival order; slow mode stalls half the time
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt     <= 3'h0;
      txReady <= 1'b0;
    end else begin
      cnt     <= cnt + 3'h1;
      txReady <= !slow || cnt[1];
      if (txOut.valid && txReady) begin
        rxQ.push_back(txOut.data);
      end
    end
  end

  // Idle request byte carries no stale value
  initial begin
    reqValid = 1'b0;
    reqByte  = 8'h5a;
  end

  // Two-byte request: subcode, then request type
  task automatic send_req(input logic [7:0] kind);
    @(posedge clock);
    reqValid <= 1'b1;
    reqByte  <= SuppSubcode;
    @(posedge clock);
    reqByte  <= kind;
    @(posedge clock);
    reqValid <= 1'b0;
    reqByte  <= ~kind;
  endtask
endmodule
`default_nettype wire

//--- tb/gtr_timing_framer_bench.sv
// Purpose: Self-checking bench for the timing report framer
// Assumes: Host model on the stream side, Avalon master tasks here
// Notes:   Expected report bytes are built from a queue model
`timescale 1ns/100ps
`default_nettype none
module gtr_timing_framer_bench;
  import gtr_pkg::*;
  logic        clock, arst_n, read, write, waitrequest, secPulse, todLoad;
  logic        surveyActive, timeOnlyMode, surveyDone, reqValid, txReady, slow;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [23:0] todLoadValue;
  logic [7:0]  reqByte;
  gtr_time_s   timeIn, t;
  gtr_pos_s    surveyPos, storedPos, fixPos;
  gtr_byte_s   txOut;
  int          num_errors, n_compared, seed, hh, mm, ss, nPrim, nSupp;
  logic [7:0]  expQ[$], mskQ[$];

  gtr_timing_framer gtr_timing_framer_i (
    .clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .secPulse(secPulse), .timeIn(timeIn), .todLoad(todLoad), .todLoadValue(todLoadValue),
    .surveyActive(surveyActive), .timeOnlyMode(timeOnlyMode), .surveyDone(surveyDone),
    .surveyPos(surveyPos), .storedPos(storedPos), .fixPos(fixPos),
    .reqValid(reqValid), .reqByte(reqByte), .txOut(txOut), .txReady(txReady));
  gtr_host_model gtr_host_model_i (
    .clock(clock), .arst_n(arst_n), .txOut(txOut), .txReady(txReady), .slow(slow),
    .reqValid(reqValid), .reqByte(reqByte));

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Masked compare of one value
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input logic [31:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Avalon access: hold until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    read      <= !wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd    = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask

  // Expected bytes, most significant first
  task automatic push(input logic [31:0] v, input int nb, input logic [7:0] m);
    for (int k = nb - 1; k >= 0; k--) begin
      expQ.push_back(v[8*k +: 8]);
      mskQ.push_back(m);
    end
  endtask

  // Primary report model
  task automatic exp_prim();
    push(PrimSubcode, 1, 8'hff);
    push(timeIn.secWeek, 4, 8'hff);
    push((timeIn.weekRaw < 10'h3ff) ? timeIn.weekRaw + 16'h0400 : timeIn.weekRaw, 2, 8'hff);
    push(timeIn.utcKnown ? timeIn.leapOffset : 16'h0000, 2, 8'hff);
    push({!timeIn.utcKnown, !timeIn.timeSet, 1'b0, timeIn.useUtc & timeIn.utcKnown}, 1,
         8'h0d);
    push({ss[7:0], mm[7:0], hh[7:0], timeIn.day}, 4, 8'hff);
    push(timeIn.month, 1, 8'hff);
    push(timeIn.year, 2, 8'hff);
    nPrim++;
  endtask

  // Supplemental report model with position choice
  task automatic exp_supp();
    gtr_pos_s p;
    logic [1:0] s;
    s = surveyActive ? 2'h1 : (surveyDone || timeOnlyMode) ? 2'h2 : 2'h0;
    p = s == 2'h1 ? surveyPos : s == 2'h2 ? storedPos : fixPos;
    push(8'hac, 1, 8'hff);
    push(s, 1, 8'hff);
    push(p.posA, 4, 8'hff);
    push(p.posB, 4, 8'hff);
    push(p.posC, 4, 8'hff);
    nSupp++;
  endtask

  // Quiet window, then compare everything received with the model
  task automatic check_stream();
    repeat (300) @(posedge clock);
    check_word(gtr_host_model_i.rxQ.size(), expQ.size(), '1);
    if (gtr_host_model_i.rxQ.size() == expQ.size()) begin
      foreach (expQ[i]) check_word(gtr_host_model_i.rxQ[i], expQ[i], mskQ[i]);
    end
    gtr_host_model_i.rxQ.delete();
    expQ.delete();
    mskQ.delete();
  endtask

  // Second pulse and time-of-day model
  task automatic pulse();
    logic leapNow;
    @(posedge clock);
    secPulse <= 1'b1;
    @(posedge clock);
    secPulse <= 1'b0;
    leapNow = hh == 23 && mm == 59 && ss == 59 && timeIn.useUtc && timeIn.leapInsert;
    ss = leapNow ? 60 : ss + 1;
    if (ss >= 60 && !leapNow) begin
      ss = 0;
      mm++;
    end
    if (mm == 60) begin
      mm = 0;
      hh++;
    end
    if (hh == 24) hh = 0;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [9:0]  wk[4];
    logic [7:0]  ctl[3];
    logic [95:0] r;
    wk = '{10'h000, 10'h3fe, 10'h3ff, 10'h2a5};
    ctl = '{8'h40, 8'h80, 8'h00};
    seed = 32'h3f1e;
    num_errors = 0;
    n_compared = 0;
    nPrim = 0;
    nSupp = 0;
    {hh, mm, ss} = '0;
    {arst_n, read, write, secPulse, todLoad, slow} = '0;
    {surveyActive, timeOnlyMode, surveyDone} = '0;
    address = 6'h00;
    writedata = 32'h0;
    todLoadValue = 24'h0;
    timeIn = '0;
    {surveyPos, storedPos, fixPos} = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    bus(1'b0, OffCtrl, 32'h0);
    check_word(rd, 32'hc0, '1);
    bus(1'b0, 6'h3c, 32'h0);
    check_word(rd, 32'h0, '1);
    bus(1'b1, OffCtrl, 32'hffffffff);
    bus(1'b0, OffCtrl, 32'h0);
    check_word(rd, 32'hc0, '1);
    // Broadcasts over week boundaries, random fields and position sources
    for (int i = 0; i < 4; i++) begin
      r = {$random(seed), $random(seed), $random(seed)};
      t = r[93:0];
      t.weekRaw = wk[i];
      t.leapInsert = 1'b0;
      timeIn <= t;
      surveyPos <= {$random(seed), $random(seed), $random(seed)};
      storedPos <= {$random(seed), $random(seed), $random(seed)};
      fixPos <= {$random(seed), $random(seed), $random(seed)};
      {surveyActive, timeOnlyMode, surveyDone} <= r[95:93];
      slow <= i[0];
      pulse();
      exp_prim();
      exp_supp();
      check_stream();
    end
    bus(1'b0, OffSecWeek, 32'h0);
    check_word(rd, timeIn.secWeek, '1);
    // Each mask bit gates its own report
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OffCtrl, {24'h0, ctl[i]});
      pulse();
      if (ctl[i][6]) exp_prim();
      if (ctl[i][7]) exp_supp();
      check_stream();
    end
    // Host requests with broadcasts off
    gtr_host_model_i.send_req(8'h00);
    exp_supp();
    check_stream();
    gtr_host_model_i.send_req(8'h01);
    check_stream();
    pulse();
    exp_supp();
    check_stream();
    gtr_host_model_i.send_req(8'h02);
    check_stream();
    pulse();
    exp_prim();
    exp_supp();
    check_stream();
    gtr_host_model_i.send_req(8'h03);
    pulse();
    check_stream();
    // Leap second insertion at end of day in UTC
    @(posedge clock);
    todLoadValue <= {8'h17, 8'h3b, 8'h3b};
    todLoad <= 1'b1;
    t = timeIn;
    {t.useUtc, t.utcKnown, t.leapInsert} = 3'h7;
    timeIn <= t;
    @(posedge clock);
    todLoad <= 1'b0;
    {hh, mm, ss} = {32'd23, 32'd59, 32'd59};
    bus(1'b1, OffCtrl, 32'h40);
    pulse();
    exp_prim();
    check_stream();
    pulse();
    exp_prim();
    check_stream();
    bus(1'b0, OffTime, 32'h0);
    check_word(rd, {8'h00, hh[7:0], mm[7:0], ss[7:0]}, '1);
    bus(1'b0, OffCount, 32'h0);
    check_word(rd, {nSupp[15:0], nPrim[15:0]}, '1);
    finish_test();
  end
endmodule
`default_nettype wire
